/* ext_irq_defs.svh */
// constants for the extended interrupt priority and external input block
`ifndef EXT_IRQ_DEFS_SVH
`define EXT_IRQ_DEFS_SVH

// ==========================================
// register addresses on the special function bus
`define ADDR_PRIO_ONE      8'hce
`define ADDR_PRIO_TWO      8'hcf
`define ADDR_INPUT_CONFIG  8'he4
`define ADDR_TIMER_CONTROL 8'h88

// ==========================================
// reset values
`define RST_PRIO_ONE       8'h00
`define RST_PRIO_TWO       8'h00
`define RST_INPUT_CONFIG   8'h01
`define RST_TIMER_CONTROL  4'h0

// ==========================================
// first priority register bit positions
`define BIT_TIMER_THREE    7
`define BIT_PRIO_ONE_RSVD  6
`define BIT_COMPARATOR     5
`define BIT_COUNTER_ARRAY  4
`define BIT_ADC_DONE       3
`define BIT_ADC_WINDOW     2
`define BIT_PORT_MATCH     1
`define BIT_TWO_WIRE       0

// second priority register bit positions and writable mask
`define BIT_CAPS_GREATER   1
`define BIT_CAPS_DONE      0
`define PRIO_TWO_MASK      8'h03

// ==========================================
// input configuration fields
`define BIT_ONE_POLARITY   7
`define FLD_ONE_SEL_HI     6
`define FLD_ONE_SEL_LO     4
`define BIT_ZERO_POLARITY  3
`define FLD_ZERO_SEL_HI    2
`define FLD_ZERO_SEL_LO    0

// timer control bits held here
`define BIT_ZERO_TRIGGER   0
`define BIT_ZERO_PENDING   1
`define BIT_ONE_TRIGGER    2
`define BIT_ONE_PENDING    3
`define TIMER_CONTROL_REG_HELD_HI       3

// ==========================================
// source numbering toward the core
`define NUM_SOURCES        11
`define SRC_EXT_ZERO       4'h0
`define SRC_EXT_ONE        4'h1
`define SRC_ONCHIP_BASE    2

`endif

/* ext_irq_pkg.sv */
// types for the extended interrupt priority and external input block
package ext_irq_pkg;
    // service level in progress, gray coded along none-low-high
    typedef enum logic [1:0] {
        svc_none = 2'b00,
        svc_low  = 2'b01,
        svc_high = 2'b11
    } svc_level_e;
    typedef logic [3:0] src_id_t;
endpackage

/* ext_interrupt_priority_logic.sv */
// extended interrupt priorities, external inputs and request selection
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_defs.svh"
// ==========================================

module ext_interrupt_priority_logic
    import ext_irq_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    input  wire logic        sfr_rd_i,
    output logic      [7:0]  sfr_rdata_o,
    input  wire logic [7:0]  port_zero_i,
    input  wire logic [1:0]  ext_enable_i,
    input  wire logic [1:0]  ext_high_prio_i,
    input  wire logic [8:0]  onchip_req_i,
    input  wire logic        vector_take_i,
    input  wire logic [3:0]  vector_id_i,
    input  wire logic        service_done_i,
    output logic             irq_req_o,
    output logic      [3:0]  irq_id_o,
    output logic             irq_high_o,
    output logic      [1:0]  ext_pending_o
);

    // ==========================================
    // registers
    logic [7:0]  ext_irq_priority_one;
    logic [7:0]  ext_irq_priority_two;
    logic [7:0]  ext_input_config;
    logic [1:0]  trigger_type;
    logic [1:0]  pending;

    logic        hit_prio_one;
    logic        hit_prio_two;
    logic        hit_config;
    logic        hit_timer;

    assign hit_prio_one = sfr_addr_i == `ADDR_PRIO_ONE;
    assign hit_prio_two = sfr_addr_i == `ADDR_PRIO_TWO;
    assign hit_config   = sfr_addr_i == `ADDR_INPUT_CONFIG;
    assign hit_timer    = sfr_addr_i == `ADDR_TIMER_CONTROL;

    // reserved bit 6 is stored as written; software keeps it zero
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_irq_priority_one <= `RST_PRIO_ONE;
        end else if (sfr_wr_i && hit_prio_one) begin
            ext_irq_priority_one <= sfr_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_irq_priority_two <= `RST_PRIO_TWO;
        end else if (sfr_wr_i && hit_prio_two) begin
            ext_irq_priority_two <= sfr_wdata_i & `PRIO_TWO_MASK;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_input_config <= `RST_INPUT_CONFIG;
        end else if (sfr_wr_i && hit_config) begin
            ext_input_config <= sfr_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trigger_type <= 2'h0;
        end else if (sfr_wr_i && hit_timer) begin
            trigger_type[0] <= sfr_wdata_i[`BIT_ZERO_TRIGGER];
            trigger_type[1] <= sfr_wdata_i[`BIT_ONE_TRIGGER];
        end
    end

    // ==========================================
    // priority map of all sources
    logic [`NUM_SOURCES-1:0] src_prio;
    logic [`NUM_SOURCES-1:0] src_req;

    assign src_prio[`SRC_EXT_ZERO] = ext_high_prio_i[0];
    assign src_prio[`SRC_EXT_ONE]  = ext_high_prio_i[1];
    assign src_prio[2]  = ext_irq_priority_one[`BIT_TIMER_THREE];
    assign src_prio[3]  = ext_irq_priority_one[`BIT_COMPARATOR];
    assign src_prio[4]  = ext_irq_priority_one[`BIT_COUNTER_ARRAY];
    assign src_prio[5]  = ext_irq_priority_one[`BIT_ADC_DONE];
    assign src_prio[6]  = ext_irq_priority_one[`BIT_ADC_WINDOW];
    assign src_prio[7]  = ext_irq_priority_one[`BIT_PORT_MATCH];
    assign src_prio[8]  = ext_irq_priority_one[`BIT_TWO_WIRE];
    assign src_prio[9]  = ext_irq_priority_two[`BIT_CAPS_GREATER];
    assign src_prio[10] = ext_irq_priority_two[`BIT_CAPS_DONE];

    assign src_req = {onchip_req_i, pending & ext_enable_i};

    // ==========================================
    // external inputs, one generate slice each
    logic [2:0] pin_sel  [2];
    logic [1:0] polarity;

    assign pin_sel[0]  = ext_input_config[`FLD_ZERO_SEL_HI:`FLD_ZERO_SEL_LO];
    assign pin_sel[1]  = ext_input_config[`FLD_ONE_SEL_HI:`FLD_ONE_SEL_LO];
    assign polarity[0] = ext_input_config[`BIT_ZERO_POLARITY];
    assign polarity[1] = ext_input_config[`BIT_ONE_POLARITY];

    // port pins come from outside the clock domain: three stages
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_s3;
    logic [7:0] pin_clean;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
            pin_s3 <= 8'h00;
        end else begin
            pin_s1 <= port_zero_i;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // a pin change counts once stages two and three agree
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_clean <= 8'h00;
        end else begin
            pin_clean <= (pin_s2 & pin_s3) | (pin_clean & (pin_s2 | pin_s3));
        end
    end

    logic [1:0] active;
    logic [1:0] active_prev;
    logic [1:0] clear_by_vector;
    logic [1:0] clear_by_write;

    assign clear_by_write[0] = sfr_wr_i && hit_timer && !sfr_wdata_i[`BIT_ZERO_PENDING];
    assign clear_by_write[1] = sfr_wr_i && hit_timer && !sfr_wdata_i[`BIT_ONE_PENDING];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ext
            logic set_by_write;
            logic edge_seen;

            // pin read from the synchronised and filtered pin_clean, crossbar untouched
            assign active[ch] = pin_clean[pin_sel[ch]] ~^ polarity[ch];
            assign clear_by_vector[ch] = vector_take_i && (vector_id_i == src_id_t'(ch));
            assign set_by_write = sfr_wr_i && hit_timer &&
                                  sfr_wdata_i[(ch == 0) ? `BIT_ZERO_PENDING : `BIT_ONE_PENDING];
            assign edge_seen = active[ch] && !active_prev[ch];

            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    active_prev[ch] <= 1'b0;
                end else begin
                    active_prev[ch] <= active[ch];
                end
            end

            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pending[ch] <= 1'b0;
                end else if (!trigger_type[ch]) begin
                    pending[ch] <= active[ch];
                end else if (edge_seen || set_by_write) begin
                    pending[ch] <= 1'b1;
                end else if (clear_by_vector[ch] || clear_by_write[ch]) begin
                    pending[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================
    // request selection, high level before low, lowest index first
    logic       found_high;
    logic       found_low;
    src_id_t    id_high;
    src_id_t    id_low;

    always_comb begin
        found_high = 1'b0;
        found_low  = 1'b0;
        id_high    = '0;
        id_low     = '0;
        for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
            if (src_req[i] && src_prio[i]) begin
                found_high = 1'b1;
                id_high    = src_id_t'(i);
            end
            if (src_req[i] && !src_prio[i]) begin
                found_low = 1'b1;
                id_low    = src_id_t'(i);
            end
        end
    end

    // ==========================================
    // service level tracking
    svc_level_e svc_level;
    svc_level_e next_svc_level;
    logic       taken_high;
    logic       low_under_high;

    assign taken_high = src_prio[vector_id_i];

    always_comb begin
        next_svc_level = svc_level;
        case (svc_level)
            svc_none: begin
                if (vector_take_i) begin
                    next_svc_level = taken_high ? svc_high : svc_low;
                end
            end
            svc_low: begin
                if (vector_take_i && taken_high) begin
                    next_svc_level = svc_high;
                end else if (service_done_i) begin
                    next_svc_level = svc_none;
                end
            end
            svc_high: begin
                // nested high over low returns to low
                if (service_done_i) begin
                    next_svc_level = low_under_high ? svc_low : svc_none;
                end
            end
            default: begin
                next_svc_level = svc_none;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_under_high <= 1'b0;
        end else if (svc_level == svc_low && next_svc_level == svc_high) begin
            low_under_high <= 1'b1;
        end else if (svc_level == svc_high && service_done_i) begin
            low_under_high <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            svc_level <= svc_none;
        end else begin
            svc_level <= next_svc_level;
        end
    end

    // ==========================================
    // request toward the core
    logic    next_req;
    logic    next_high;
    src_id_t next_id;

    always_comb begin
        next_req  = 1'b0;
        next_high = 1'b0;
        next_id   = '0;
        if (found_high && svc_level != svc_high) begin
            next_req  = 1'b1;
            next_high = 1'b1;
            next_id   = id_high;
        end else if (found_low && svc_level == svc_none) begin
            next_req  = 1'b1;
            next_id   = id_low;
        end
    end

    // request dropped on the edge that registers the core's take, not one cycle after it
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_req_o  <= 1'b0;
            irq_id_o   <= '0;
            irq_high_o <= 1'b0;
        end else begin
            irq_req_o  <= next_req && !vector_take_i;
            irq_id_o   <= next_id;
            irq_high_o <= next_high;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_pending_o <= 2'h0;
        end else begin
            ext_pending_o <= pending;
        end
    end

    // ==========================================
    // read back
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (hit_prio_one) begin
            next_rdata = ext_irq_priority_one;
        end else if (hit_prio_two) begin
            next_rdata = ext_irq_priority_two;
        end else if (hit_config) begin
            next_rdata = ext_input_config;
        end else if (hit_timer) begin
            next_rdata[`BIT_ZERO_TRIGGER] = trigger_type[0];
            next_rdata[`BIT_ZERO_PENDING] = pending[0];
            next_rdata[`BIT_ONE_TRIGGER]  = trigger_type[1];
            next_rdata[`BIT_ONE_PENDING]  = pending[1];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= next_rdata;
        end
    end

endmodule // ext_interrupt_priority_logic
`default_nettype wire

/* ext_irq_assertions.sv */
// port-level assertions for the extended interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_defs.svh"
// ==========================================
// checker
module ext_irq_checker
    import ext_irq_pkg::*;
(
    input wire logic       sys_clk_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic       sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [7:0] port_zero_i,
    input wire logic [1:0] ext_enable_i,
    input wire logic [1:0] ext_high_prio_i,
    input wire logic [8:0] onchip_req_i,
    input wire logic       vector_take_i,
    input wire logic [3:0] vector_id_i,
    input wire logic       service_done_i,
    input wire logic       irq_req_o,
    input wire logic [3:0] irq_id_o,
    input wire logic       irq_high_o,
    input wire logic [1:0] ext_pending_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_prio_one_readback: assert property (
        sfr_wr_i && sfr_addr_i == `ADDR_PRIO_ONE ##1 sfr_rd_i && !sfr_wr_i && sfr_addr_i == `ADDR_PRIO_ONE
        |=> sfr_rdata_o == $past(sfr_wdata_i, 2)) else $error("first priority readback wrong");
    a_prio_two_readback: assert property (
        sfr_wr_i && sfr_addr_i == `ADDR_PRIO_TWO ##1 sfr_rd_i && !sfr_wr_i && sfr_addr_i == `ADDR_PRIO_TWO
        |=> sfr_rdata_o == ($past(sfr_wdata_i, 2) & `PRIO_TWO_MASK)) else $error("second priority readback wrong");
    a_config_readback: assert property (
        sfr_wr_i && sfr_addr_i == `ADDR_INPUT_CONFIG ##1 sfr_rd_i && !sfr_wr_i && sfr_addr_i == `ADDR_INPUT_CONFIG
        |=> sfr_rdata_o == $past(sfr_wdata_i, 2)) else $error("input config readback wrong");
    a_timer_control_reg_rsvd_zero: assert property (
        sfr_rd_i && sfr_addr_i == `ADDR_TIMER_CONTROL |=> sfr_rdata_o[7:4] == 4'h0)
        else $error("timer control upper bits not zero");
    a_pending_mirror: assert property (
        sfr_rd_i && sfr_addr_i == `ADDR_TIMER_CONTROL
        |=> sfr_rdata_o[1] == ext_pending_o[0] && sfr_rdata_o[3] == ext_pending_o[1])
        else $error("pending flags misplaced in timer control");
    a_high_blocks_all: assert property (
        vector_take_i && irq_high_o && vector_id_i == irq_id_o |-> ##2 !irq_req_o)
        else $error("request during high service");
    a_low_no_preempt: assert property (
        vector_take_i && !irq_high_o && vector_id_i == irq_id_o |-> ##2 (!irq_req_o || irq_high_o))
        else $error("low request during low service");
    a_req_has_cause: assert property (
        $rose(irq_req_o) |-> $past(onchip_req_i) != 9'h000 || (ext_pending_o & $past(ext_enable_i)) != 2'h0)
        else $error("request without a source");
endmodule // ext_irq_checker

bind ext_interrupt_priority_logic ext_irq_checker i_ext_irq_checker (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .port_zero_i(port_zero_i),
    .ext_enable_i(ext_enable_i), .ext_high_prio_i(ext_high_prio_i), .onchip_req_i(onchip_req_i),
    .vector_take_i(vector_take_i), .vector_id_i(vector_id_i), .service_done_i(service_done_i),
    .irq_req_o(irq_req_o), .irq_id_o(irq_id_o), .irq_high_o(irq_high_o), .ext_pending_o(ext_pending_o));
`default_nettype wire

/* core_vector_model.sv */
// behavioural model of the core's interrupt vectoring
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// core model
module core_vector_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       go_i,
    input  wire logic [3:0] lag_i,
    input  wire logic [3:0] hold_i,
    input  wire logic       req_i,
    input  wire logic [3:0] id_i,
    output logic            take_o,
    output logic      [3:0] id_o,
    output logic            done_o
);
    initial begin
        take_o = 1'b0;
        id_o   = 4'h0;
        done_o = 1'b0;
        forever begin
            @(posedge clk_i);
            // look after the bench has settled its own controls
            #2;
            if (rst_n_i && go_i && req_i) begin
                repeat (lag_i) @(posedge clk_i);
                #1;
                if (req_i) begin
                    take_o = 1'b1;
                    id_o   = id_i;
                    @(posedge clk_i);
                    #1 take_o = 1'b0;
                    // id has no meaning once released
                    id_o = ~id_o;
                    repeat (hold_i) @(posedge clk_i);
                    #1 done_o = 1'b1;
                    @(posedge clk_i);
                    #1 done_o = 1'b0;
                end
            end
        end
    end
endmodule // core_vector_model
`default_nettype wire

/* ext_interrupt_priority_logic_tb.sv */
// self-checking bench for the extended interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_defs.svh"
// ==========================================
// bench top
module ext_interrupt_priority_logic_tb import ext_irq_pkg::*;;
    logic       sys_clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, port_zero_i = 8'hff, sfr_rdata_o;
    logic       sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, go = 1'b0;
    logic       vector_take_i, service_done_i, irq_req_o, irq_high_o;
    logic [1:0] ext_enable_i = 2'h0, ext_high_prio_i = 2'h0, ext_pending_o;
    logic [8:0] onchip_req_i = 9'h000;
    logic [3:0] vector_id_i, irq_id_o, hold = 4'h3;
    int         error_cnt = 0, comparisons = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    ext_interrupt_priority_logic i_ext_interrupt_priority_logic (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .port_zero_i(port_zero_i),
        .ext_enable_i(ext_enable_i), .ext_high_prio_i(ext_high_prio_i), .onchip_req_i(onchip_req_i),
        .vector_take_i(vector_take_i), .vector_id_i(vector_id_i), .service_done_i(service_done_i),
        .irq_req_o(irq_req_o), .irq_id_o(irq_id_o), .irq_high_o(irq_high_o), .ext_pending_o(ext_pending_o));
    core_vector_model i_core_vector_model (
        .clk_i(sys_clk_i), .rst_n_i(rst_n_i), .go_i(go), .lag_i(4'h1), .hold_i(hold), .req_i(irq_req_o),
        .id_i(irq_id_o), .take_o(vector_take_i), .id_o(vector_id_i), .done_o(service_done_i));

    // ==========================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        // one idle edge so a strobe never drops and rises in one step
        tick(1);
        sfr_addr_i  = a;
        sfr_wdata_i = d;
        sfr_wr_i    = 1'b1;
        tick(1);
        sfr_wr_i = 1'b0;
    endtask
    task automatic reg_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        sfr_addr_i = a;
        sfr_rd_i   = 1'b1;
        tick(1);
        sfr_rd_i = 1'b0;
        check(what, sfr_rdata_o, exp);
        tick(1);
    endtask
    function automatic logic prio_of(input int i, input logic [7:0] p1, input logic [7:0] p2);
        logic [8:0] m;
        m = {p2[0], p2[1], p1[0], p1[1], p1[2], p1[3], p1[4], p1[5], p1[7]};
        return m[i];
    endfunction
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================
    // tests
    initial begin
        logic [7:0] a, d, p1, p2, cfg, pins;
        int k, p, t, s;
        void'($urandom(29));
        tick(10);
        rst_n_i = 1'b1;
        reg_chk("prio_one_rst", `ADDR_PRIO_ONE, `RST_PRIO_ONE);
        reg_chk("prio_two_rst", `ADDR_PRIO_TWO, `RST_PRIO_TWO);
        reg_chk("config_rst", `ADDR_INPUT_CONFIG, `RST_INPUT_CONFIG);
        reg_chk("timer_control_reg_rst", `ADDR_TIMER_CONTROL, {4'h0, `RST_TIMER_CONTROL});
        for (int i = 0; i < 4; i++) begin
            a = $urandom;
            if (a inside {`ADDR_PRIO_ONE, `ADDR_PRIO_TWO, `ADDR_INPUT_CONFIG, `ADDR_TIMER_CONTROL}) a = 8'h00;
            d = $urandom;
            reg_wr(a, d);
            reg_chk("unmapped", a, 8'h00);
            reg_wr(`ADDR_PRIO_TWO, d);
            reg_chk("prio_two", `ADDR_PRIO_TWO, d & `PRIO_TWO_MASK);
            reg_wr(`ADDR_INPUT_CONFIG, d);
            reg_chk("config", `ADDR_INPUT_CONFIG, d);
        end
        tick(8);
        // edge mode first, so the pending set below is not a level write
        reg_wr(`ADDR_TIMER_CONTROL, 8'h05);
        reg_wr(`ADDR_TIMER_CONTROL, 8'hff);
        reg_chk("timer_control_reg_set", `ADDR_TIMER_CONTROL, 8'h0f);
        reg_wr(`ADDR_TIMER_CONTROL, 8'h05);
        reg_chk("timer_control_reg_clear", `ADDR_TIMER_CONTROL, 8'h05);
        $display("registers done");
        for (int i = 0; i < 9; i++) begin
            p1 = $urandom;
            p2 = $urandom;
            reg_wr(`ADDR_PRIO_TWO, p2);
            reg_wr(`ADDR_PRIO_ONE, p1);
            reg_chk("prio_one", `ADDR_PRIO_ONE, p1);
            onchip_req_i = 9'h001 << i;
            tick(3);
            check("onchip", {irq_req_o, irq_high_o, 2'b00, irq_id_o}, {1'b1, prio_of(i, p1, p2), 6'(i + 2)});
            onchip_req_i = 9'h000;
            tick(2);
        end
        $display("priorities done");
        for (int n = 0; n < 8; n++) begin
            k = n % 2;
            p = (n / 2) % 2;
            t = n / 4;
            s = $urandom_range(7);
            ext_enable_i    = 2'(1 << k);
            ext_high_prio_i = 2'($urandom);
            cfg = $urandom;
            if (k == 0) cfg[3:0] = {1'(p), 3'(s)};
            else cfg[7:4] = {1'(p), 3'(s)};
            reg_wr(`ADDR_TIMER_CONTROL, 8'h00);
            reg_wr(`ADDR_INPUT_CONFIG, cfg);
            pins = $urandom;
            pins[s] = ~1'(p);
            // pin s serves only the input, as if skipped in the crossbar
            port_zero_i = pins;
            tick(8);
            reg_wr(`ADDR_TIMER_CONTROL, 8'(t << (2 * k)));
            tick(8);
            check("pend_idle", 8'(ext_pending_o[k]), 8'h00);
            pins = $urandom;
            pins[s] = 1'(p);
            port_zero_i = pins;
            tick(8);
            check("pend_active", 8'(ext_pending_o[k]), 8'h01);
            check("ext_req", {irq_req_o, irq_high_o, 2'b00, irq_id_o}, {1'b1, ext_high_prio_i[k], 6'(k)});
            // source withdraws before the core takes the request
            pins[s] = ~1'(p);
            port_zero_i = pins;
            tick(8);
            check("pend_after", 8'(ext_pending_o[k]), 8'(t));
            if (t == 1) begin
                go = 1'b1;
                tick(14);
                go = 1'b0;
                check("pend_taken", 8'(ext_pending_o[k]), 8'h00);
            end
        end
        $display("external inputs done");
        ext_enable_i = 2'h0;
        reg_wr(`ADDR_PRIO_ONE, 8'h80);
        reg_wr(`ADDR_PRIO_TWO, 8'h00);
        hold = 4'hf;
        go   = 1'b1;
        onchip_req_i = 9'h002;
        tick(6);
        onchip_req_i = 9'h000;
        tick(2);
        onchip_req_i = 9'h004;
        tick(3);
        check("low_blocked", 8'(irq_req_o), 8'h00);
        onchip_req_i = 9'h005;
        tick(3);
        check("high_preempts", {irq_req_o, irq_high_o, 2'b00, irq_id_o}, 8'hc2);
        onchip_req_i = 9'h000;
        go = 1'b0;
        tick(20);
        $display("preemption done");
        test_done();
    end

    initial begin
        repeat (5000) @(posedge sys_clk_i);
        error_cnt++;
        test_done();
    end
endmodule // ext_interrupt_priority_logic_tb
`default_nettype wire
